// *** inc/random_generator_map.svh ***
// Register offsets, field positions, reset values and timing counts.
`ifndef RANDOM_GENERATOR_MAP_SVH
`define RANDOM_GENERATOR_MAP_SVH

// -------------------------------------------------------------------------
// Register indices; the byte address on the bus is four times the index.
// -------------------------------------------------------------------------
`define IDX_CONTROL_MAIN 6'h00
`define IDX_EVENT_CONTROL 6'h04
`define IDX_IRQ_ENABLE_CLEAR 6'h08
`define IDX_IRQ_ENABLE_SET 6'h09
`define IDX_IRQ_FLAGS 6'h0A
`define IDX_RANDOM_OUTPUT 6'h20

// -------------------------------------------------------------------------
// Field positions.
// -------------------------------------------------------------------------
`define BIT_ENABLE 1
`define BIT_RUN_IN_STANDBY 6
`define BIT_READY_EVENT_OUTPUT_ENABLE 0
`define BIT_READY 0

// -------------------------------------------------------------------------
// Reset values and timing.
// -------------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_RANDOM_OUTPUT 32'h00000000
`define RST_NOISE_SEED 32'h1D2C3B4A
`define WORD_CYCLES 7'h54
`define WORD_LAST 7'h53

`endif

// *** inc/random_generator_pkg.sv ***
// Types shared by the random generator register block.
package random_generator_pkg;

  typedef logic [31:0] word_t;
  typedef logic [1:0] resp_t;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_e;

endpackage

// *** core/random_generator.sv ***
// Register, flag and word-generation logic of the random generator.
`timescale 1ns/10ps
`include "random_generator_map.svh"

// -------------------------------------------------------------------------
// -------------------------------------------------------------------------

module random_generator (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic standby,
  input wire logic awvalid,
  output logic awready,
  input wire random_generator_pkg::word_t awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire random_generator_pkg::word_t wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output random_generator_pkg::resp_t bresp,
  input wire logic arvalid,
  output logic arready,
  input wire random_generator_pkg::word_t araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output random_generator_pkg::word_t rdata,
  output random_generator_pkg::resp_t rresp,
  output logic irq,
  output logic ready_event
);
  import random_generator_pkg::*;

  // -----------------------------------------------------------------------
  // Address decode.
  // -----------------------------------------------------------------------
  // Only word-aligned addresses within the low 256 bytes map to registers.
  function automatic logic hit(input word_t addr, input logic [5:0] idx);
    hit = (addr[31:8] == 24'h000000) && (addr[7:2] == idx)
      && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic mapped(input word_t addr);
    mapped = hit(addr, `IDX_CONTROL_MAIN) || hit(addr, `IDX_EVENT_CONTROL)
      || hit(addr, `IDX_IRQ_ENABLE_CLEAR) || hit(addr, `IDX_IRQ_ENABLE_SET)
      || hit(addr, `IDX_IRQ_FLAGS) || hit(addr, `IDX_RANDOM_OUTPUT);
  endfunction

  // -----------------------------------------------------------------------
  // State.
  // -----------------------------------------------------------------------
  logic enable;
  logic run_in_standby;
  logic ready_event_output_enable;
  logic ready_irq_enable;
  logic ready_flag;
  word_t random_output;
  word_t noise;
  logic [6:0] cycle_cnt;
  logic aw_held;
  word_t aw_addr;
  logic w_held;
  word_t w_data;
  logic [3:0] w_strb;
  logic next_enable;
  logic next_run_in_standby;
  logic next_ready_event_output_enable;
  logic next_ready_irq_enable;
  logic next_ready_flag;
  word_t next_random_output;
  word_t next_noise;
  logic [6:0] next_cycle_cnt;
  logic next_ready_event;
  logic next_aw_held;
  word_t next_aw_addr;
  logic next_w_held;
  word_t next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  resp_t next_bresp;
  logic next_rvalid;
  word_t next_rdata;
  resp_t next_rresp;

  logic running;
  logic word_done;
  logic do_write;
  logic do_read;
  logic wr_low;

  // -----------------------------------------------------------------------
  // Handshakes, strobes and the interrupt.
  // -----------------------------------------------------------------------
  // Standby halts the source unless run_in_standby is set, and leaves every setting in place.
  assign running = enable && (!standby || run_in_standby);
  assign word_done = running && (cycle_cnt == `WORD_LAST);
  // A write lands only once address and data are both parked and the
  // previous response has been taken, so no response is ever overwritten.
  assign do_write = aw_held && w_held && !bvalid;
  assign do_read = arvalid && arready;
  // Only the low byte lane carries register bits; other lanes are dropped.
  assign wr_low = do_write && w_strb[0];
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;
  // The interrupt is a level of two flip-flops, so it cannot glitch on a
  // bus access and falls in the cycle that the flag or the enable drops.
  assign irq = ready_flag && ready_irq_enable;

  // -----------------------------------------------------------------------
  // Bus channels: next values.
  // -----------------------------------------------------------------------
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;

    // Write channels are taken independently and held until both are in.
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken.
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      next_rdata = 32'h00000000;
      if (hit(araddr, `IDX_CONTROL_MAIN)) begin
        next_rdata[`BIT_ENABLE] = enable;
        next_rdata[`BIT_RUN_IN_STANDBY] = run_in_standby;
      end
      if (hit(araddr, `IDX_EVENT_CONTROL)) begin
        next_rdata[`BIT_READY_EVENT_OUTPUT_ENABLE] =
          ready_event_output_enable;
      end
      if (hit(araddr, `IDX_IRQ_ENABLE_CLEAR)
          || hit(araddr, `IDX_IRQ_ENABLE_SET)) begin
        next_rdata[`BIT_READY] = ready_irq_enable;
      end
      if (hit(araddr, `IDX_IRQ_FLAGS)) begin
        next_rdata[`BIT_READY] = ready_flag;
      end
      if (hit(araddr, `IDX_RANDOM_OUTPUT)) begin
        next_rdata = random_output;
      end
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // Settings, flag and word generation: next values.
  // -----------------------------------------------------------------------
  always_comb begin
    next_enable = enable;
    next_run_in_standby = run_in_standby;
    next_ready_event_output_enable = ready_event_output_enable;
    next_ready_irq_enable = ready_irq_enable;
    next_ready_flag = ready_flag;
    next_random_output = random_output;
    next_noise = noise;
    next_cycle_cnt = cycle_cnt;

    // Word generation; the noise register stands in for the entropy source.
    if (!enable) begin
      next_cycle_cnt = 7'h00;
    end else if (running) begin
      next_noise = {noise[30:0], noise[31] ^ noise[21] ^ noise[1] ^ noise[0]};
      if (word_done) begin
        next_cycle_cnt = 7'h00;
        next_random_output = noise;
      end else begin
        next_cycle_cnt = cycle_cnt + 7'h01;
      end
    end
    next_ready_event = word_done && ready_event_output_enable;

    // Settings change at the edge that raises the write response.
    if (wr_low && hit(aw_addr, `IDX_CONTROL_MAIN)) begin
      next_enable = w_data[`BIT_ENABLE];
      next_run_in_standby = w_data[`BIT_RUN_IN_STANDBY];
    end
    // A write while enable is set is still answered OKAY, so software that does
    // not read back will not notice that it was dropped.
    if (wr_low && hit(aw_addr, `IDX_EVENT_CONTROL) && !enable) begin
      next_ready_event_output_enable =
        w_data[`BIT_READY_EVENT_OUTPUT_ENABLE];
    end
    if (wr_low && hit(aw_addr, `IDX_IRQ_ENABLE_CLEAR)
        && w_data[`BIT_READY]) begin
      next_ready_irq_enable = 1'b0;
    end
    if (wr_low && hit(aw_addr, `IDX_IRQ_ENABLE_SET)
        && w_data[`BIT_READY]) begin
      next_ready_irq_enable = 1'b1;
    end
    if (wr_low && hit(aw_addr, `IDX_IRQ_FLAGS) && w_data[`BIT_READY]) begin
      next_ready_flag = 1'b0;
    end
    // Handing over the output word also drops the flag.
    if (do_read && hit(araddr, `IDX_RANDOM_OUTPUT)) begin
      next_ready_flag = 1'b0;
    end

    // A completing word wins over any clear in the same cycle.
    if (word_done) begin
      next_ready_flag = 1'b1;
    end
  end

  // -----------------------------------------------------------------------
  // Bus channel registers.
  // -----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h00000000;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // -----------------------------------------------------------------------
  // Setting, flag and generator registers.
  // -----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable <= 1'b0;
      run_in_standby <= 1'b0;
      ready_event_output_enable <= 1'b0;
      ready_irq_enable <= 1'b0;
      ready_flag <= 1'b0;
      random_output <= `RST_RANDOM_OUTPUT;
      noise <= `RST_NOISE_SEED;
      cycle_cnt <= 7'h00;
      ready_event <= 1'b0;
    end else begin
      enable <= next_enable;
      run_in_standby <= next_run_in_standby;
      ready_event_output_enable <= next_ready_event_output_enable;
      ready_irq_enable <= next_ready_irq_enable;
      ready_flag <= next_ready_flag;
      random_output <= next_random_output;
      noise <= next_noise;
      cycle_cnt <= next_cycle_cnt;
      ready_event <= next_ready_event;
    end
  end

endmodule

// *** testbench/random_generator_chk.sv ***
// Port-level assertions for the random generator register block.
`timescale 1ns/10ps
module random_generator_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic irq,
  input wire logic ready_event
);
  // ------
  // Cycles since the last event; it saturates so a first event is legal.
  // ------
  logic [6:0] gap;
  logic [6:0] next_gap;
  always_comb begin
    next_gap = (gap == 7'h7F) ? gap : gap + 7'h01;
    if (ready_event) begin
      next_gap = 7'h00;
    end
  end
  always_ff @(posedge aclk) begin
    gap <= aresetn ? next_gap : 7'h7F;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (awvalid && awready && wvalid && wready
    |-> ##2 bvalid) else $error("write not answered");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  a_write_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answering");
  a_read_blocked: assert property (rvalid |-> !arready)
    else $error("read taken while answering");
  a_event_single: assert property (ready_event |=> !ready_event)
    else $error("event longer than one cycle");
  a_event_gap: assert property (ready_event |-> gap >= 7'h53)
    else $error("events closer than a word period");
  a_irq_fall: assert property ($fell(irq)
    |-> $rose(bvalid) || $rose(rvalid))
    else $error("interrupt dropped without a bus access");
  a_irq_hold: assert property ((irq && !bvalid && !rvalid)
    ##1 (!bvalid && !rvalid) |-> irq)
    else $error("interrupt not held");
  c_event: cover property (ready_event);
  c_read_clear: cover property ($fell(irq) && $rose(rvalid));
  c_write_clear: cover property ($fell(irq) && $rose(bvalid));
endmodule
bind random_generator random_generator_chk random_generator_chk_i (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .irq(irq), .ready_event(ready_event));

// *** testbench/random_generator_master.sv ***
// Bus master model standing in for processor software.
`timescale 1ns/10ps
module random_generator_master (
  input wire logic aclk,
  output logic awvalid,
  input wire logic awready,
  output random_generator_pkg::word_t awaddr,
  output logic wvalid,
  input wire logic wready,
  output random_generator_pkg::word_t wdata,
  input wire logic bvalid,
  output logic bready,
  input wire random_generator_pkg::resp_t bresp,
  output logic arvalid,
  input wire logic arready,
  output random_generator_pkg::word_t araddr,
  input wire logic rvalid,
  output logic rready,
  input wire random_generator_pkg::word_t rdata,
  input wire random_generator_pkg::resp_t rresp,
  output logic hang
);
  import random_generator_pkg::*;
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, hang} = 6'h00;
    awaddr = 32'h00;
    wdata = 32'h00;
    araddr = 32'h00;
  end
  // Released payloads are inverted so a stale value is never mistaken.
  task automatic wr(input word_t a, input word_t d, output resp_t r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    hang <= (n == 99);
  endtask
  task automatic rd(input word_t a, output word_t d, output resp_t r);
    int n;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    hang <= (n == 99);
  endtask
endmodule

// *** testbench/random_generator_bench.sv ***
// Self-checking bench for the random generator register block.
`timescale 1ns/10ps
module random_generator_bench;
  import random_generator_pkg::*;
  logic aclk = 0, aresetn = 0, standby = 0;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, irq, ready_event, hang;
  word_t awaddr, wdata, araddr, rdata, d;
  resp_t bresp, rresp, r;
  int n_errors = 0, n_compared = 0, n;
  always #2.5 aclk = ~aclk;
  random_generator random_generator_i (.aclk(aclk), .aresetn(aresetn),
    .standby(standby), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .irq(irq), .ready_event(ready_event));
  random_generator_master random_generator_master_i (.aclk(aclk),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .hang(hang));
  task automatic chk_w(input word_t got, input word_t exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input word_t a, input word_t v);
    random_generator_master_i.wr(a, v, r);
    chk_w(word_t'(r), word_t'(RESP_OKAY));
  endtask
  task automatic rc(input word_t a, input word_t e, input resp_t er);
    random_generator_master_i.rd(a, d, r);
    chk_w(d, e);
    chk_w(word_t'(r), word_t'(er));
  endtask
  // Counts edges until an event is seen; lim + 1 means none came.
  task automatic wait_ev(input int lim);
    for (n = 1; n <= lim; n++) begin
      @(posedge aclk);
      if (ready_event === 1'b1) break;
    end
  endtask
  task automatic t_reset;
    wr(32'h80, 32'hFFFFFFFF);
    rc(32'h00, 32'h00, RESP_OKAY);
    rc(32'h10, 32'h00, RESP_OKAY);
    rc(32'h24, 32'h00, RESP_OKAY);
    rc(32'h28, 32'h00, RESP_OKAY);
    rc(32'h80, 32'h00, RESP_OKAY);
    rc(32'h04, 32'h00, RESP_SLVERR);
    $display("reset test done");
  endtask
  task automatic t_protect;
    wr(32'h10, 32'h01);
    rc(32'h10, 32'h01, RESP_OKAY);
    wr(32'h00, 32'h02);
    wr(32'h10, 32'h00);
    rc(32'h10, 32'h01, RESP_OKAY);
    $display("protect test done");
  endtask
  task automatic t_word;
    wr(32'h24, 32'h01);
    rc(32'h20, 32'h01, RESP_OKAY);
    wait_ev(200);
    wait_ev(200);
    chk_w(word_t'(n), 32'h54);
    chk_b(irq, 1'b1);
    wr(32'h28, 32'h00);
    rc(32'h28, 32'h01, RESP_OKAY);
    random_generator_master_i.rd(32'h80, d, r);
    chk_b(d !== 32'h00, 1'b1);
    chk_b(irq, 1'b0);
    wait_ev(200);
    wr(32'h28, 32'h01);
    chk_b(irq, 1'b0);
    wait_ev(200);
    wr(32'h20, 32'h01);
    chk_b(irq, 1'b0);
    rc(32'h24, 32'h00, RESP_OKAY);
    $display("word test done");
  endtask
  task automatic t_standby;
    standby <= 1'b1;
    wait_ev(170);
    chk_w(word_t'(n), 32'hAB);
    wr(32'h00, 32'h42);
    wait_ev(170);
    chk_b(n < 86, 1'b1);
    wr(32'h00, 32'h40);
    wr(32'h28, 32'h01);
    wait_ev(170);
    chk_w(word_t'(n), 32'hAB);
    rc(32'h28, 32'h00, RESP_OKAY);
    wr(32'h00, 32'h42);
    wait_ev(170);
    chk_b(n > 83 && n < 86, 1'b1);
    wr(32'h00, 32'h40);
    wr(32'h28, 32'h01);
    wr(32'h10, 32'h00);
    wr(32'h00, 32'h42);
    wait_ev(170);
    chk_w(word_t'(n), 32'hAB);
    rc(32'h28, 32'h01, RESP_OKAY);
    standby <= 1'b0;
    $display("standby test done");
  endtask
  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    if (hang === 1'b1) begin
      n_errors++;
      test_done;
    end
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_protect;
    t_word;
    t_standby;
    test_done;
  end
endmodule
